// File: core/qsc_pkg.sv
package qsc_pkg;

   // Register byte offsets
   localparam logic [7:0] CTRL_OFS      = 8'h00;
   localparam logic [7:0] SESS_OFS      = 8'h04;
   localparam logic [7:0] ATTR_HDR_OFS  = 8'h08;
   localparam logic [7:0] ATTR_GRP_OFS  = 8'h0C;
   localparam logic [7:0] ATTR_VAL_OFS  = 8'h10;
   localparam logic [7:0] STATUS_OFS    = 8'h14;
   localparam logic [7:0] RATE_SEL_OFS  = 8'h18;
   localparam logic [7:0] RATE_PAIR_OFS = 8'h1C;
   localparam logic [7:0] FREQ_OFS      = 8'h20;
   localparam logic [7:0] POWER_OFS     = 8'h24;
   localparam logic [7:0] MODE_OFS      = 8'h28;
   localparam logic [7:0] RATE_OFS      = 8'h2C;

   // Control and status bit positions
   localparam int CTRL_UDP_BIT    = 0;
   localparam int CTRL_STREAM_BIT = 1;
   localparam int CTRL_VAR_BIT    = 2;
   localparam int CTRL_APPLY_BIT  = 3;
   localparam int CTRL_EN_BIT     = 4;
   localparam int ST_ATTR_ERR_BIT = 0;
   localparam int ST_REFUSED_BIT  = 1;
   localparam int ST_LOCK_BIT     = 2;
   localparam int ST_APPLIED_BIT  = 3;
   localparam int ST_DISC_BIT     = 4;
   localparam int ST_DISCARD_BIT  = 5;

   // Attribute type codes and lengths
   localparam logic [15:0] TYPE_FREQ  = 16'h0065;
   localparam logic [15:0] TYPE_POWER = 16'h0066;
   localparam logic [15:0] TYPE_MOD   = 16'h0067;
   localparam logic [15:0] TYPE_ANNEX = 16'h0068;
   localparam logic [15:0] TYPE_RATE  = 16'h0069;
   localparam logic [15:0] TYPE_ILV   = 16'h006A;
   localparam logic [15:0] TYPE_MUTE  = 16'h006B;
   localparam logic [9:0]  LEN_FREQ   = 10'h00C;
   localparam logic [9:0]  LEN_SHORT  = 10'h008;
   localparam logic [9:0]  LEN_WORD   = 10'h00A;
   localparam logic [9:0]  LEN_PAIR   = 10'h004;
   localparam logic [3:0]  MOD_LAST   = 4'h1;
   localparam logic [3:0]  ANNEX_LAST = 4'h2;
   localparam logic [31:0] VAR_PAIR   = 32'hFFFFFFFF;

   // Packet layout
   localparam logic [15:0] UDP_LEN      = 16'h0008;
   localparam logic [15:0] HDR_LAST     = 16'h0007;
   localparam logic [15:0] SUB_LAST     = 16'h0003;
   localparam logic [3:0]  L2_VERSION   = 4'h3;
   localparam logic [13:0] MPEG_SEG_LEN = 14'h00BC;

   localparam int RATE_PAIRS = 8;
   localparam int MAX_SEG    = 16;

   typedef enum logic [2:0] {P_IDLE, P_HDR, P_SUB, P_TABLE, P_PAY, P_DROP} qsc_parse_e;

   typedef struct packed {
      logic [31:0] freq;
      logic [15:0] power;
      logic [3:0]  modulation;
      logic [3:0]  annex;
      logic [15:0] rate_m;
      logic [15:0] rate_n;
      logic [7:0]  ilv_i;
      logic [7:0]  ilv_j;
      logic        mute;
      logic [6:0]  mute_group;
      logic [6:0]  attr_group;
   } qsc_phy_s;

   typedef struct packed {
      logic        valid;
      logic [7:0]  data;
      logic        first;
      logic        last;
   } qsc_seg_s;

   typedef struct packed {
      logic        ack;
      logic [31:0] rdata;
      logic        udp;
      logic        sess_stream;
      logic        var_rate;
      logic        parse_en;
      logic [31:0] sess_id;
      logic [15:0] a_type;
      logic [9:0]  a_len;
      logic [6:0]  a_group;
      logic [31:0] a_value;
      qsc_phy_s    stage;
      qsc_phy_s    active;
      logic [5:0]  status;
      logic [2:0]  rate_idx;
      logic [3:0]  rate_cnt;
      logic [RATE_PAIRS-1:0][31:0] pairs;
      qsc_parse_e  st;
      logic [15:0] off;
      logic        pkt_stream;
      logic [6:0]  seg_cnt;
      logic [6:0]  seg_idx;
      logic [13:0] seg_rem;
      logic        new_seg;
      logic [MAX_SEG-1:0][13:0] lens;
      qsc_seg_s    seg;
      logic        disc;
   } qsc_state_s;

endpackage

// File: core/qsc_top.sv
// Decided for this implementation: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/100ps
module qsc_top
(
   input  wire logic              ref_clk_i,
   input  wire logic              rstn_i,
   input  wire logic [7:0]        avs_address_i,
   input  wire logic              avs_read_i,
   input  wire logic              avs_write_i,
   input  wire logic [31:0]       avs_writedata_i,
   input  wire logic [3:0]        avs_byteenable_i,
   output logic [31:0]            avs_readdata_o,
   output logic                   avs_waitrequest_o,
   input  wire logic              pkt_valid_i,
   input  wire logic [7:0]        pkt_data_i,
   input  wire logic              pkt_sop_i,
   input  wire logic              pkt_eop_i,
   input  wire logic              pkt_stream_i,
   output logic                   pkt_ready_o,
   output qsc_pkg::qsc_seg_s      seg_o,
   output logic                   disconnect_o,
   output qsc_pkg::qsc_phy_s      phy_o
);

   ////////////////////////////////////////////////////////////////////////////
   // Reset release

   logic rst_meta;
   logic rst_q;

   always_ff @(posedge ref_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         rst_meta <= 1'b0;
         rst_q    <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rst_q    <= rst_meta;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State

   qsc_pkg::qsc_state_s s;
   qsc_pkg::qsc_state_s next_s;

   logic        req;
   logic        wr_now;
   logic [31:0] cur;
   logic [31:0] mask;
   logic [31:0] wd;
   logic        lock;
   logic        rate_ok;
   logic        vb;
   logic [15:0] hoff;
   logic [15:0] o;
   logic        in_hdr;
   logic [1:0]  k;
   logic [13:0] rem_now;

   assign req               = avs_read_i | avs_write_i;
   assign wr_now            = avs_write_i & s.ack;
   assign avs_waitrequest_o = req & ~s.ack;
   assign avs_readdata_o    = s.rdata;
   assign pkt_ready_o       = rst_q;
   assign seg_o             = s.seg;
   assign disconnect_o      = s.disc;
   assign phy_o             = s.active;
   assign lock              = (s.rate_cnt != 4'h0) & ~s.var_rate;
   assign vb                = pkt_valid_i & s.parse_en & rst_q;
   assign hoff              = s.udp ? qsc_pkg::UDP_LEN : 16'h0000;
   assign in_hdr            = (s.st == qsc_pkg::P_HDR) | ((s.st == qsc_pkg::P_IDLE) & pkt_sop_i);
   assign o                 = (s.st == qsc_pkg::P_IDLE) ? 16'h0000 : s.off;
   assign k                 = 2'(o - hoff);

   always_comb
   begin
      for (int i = 0; i < 4; i++)
         mask[8*i +: 8] = {8{avs_byteenable_i[i]}};
   end

   // Register readback, also the base for byte-lane merging
   always_comb
   begin
      cur = 32'h00000000;
      case (avs_address_i & 8'hFC)
         qsc_pkg::CTRL_OFS:
            cur = {27'h0, s.parse_en, 1'b0, s.var_rate, s.sess_stream, s.udp};
         qsc_pkg::SESS_OFS:     cur = s.sess_id;
         qsc_pkg::ATTR_HDR_OFS: cur = {6'h00, s.a_len, s.a_type};
         qsc_pkg::ATTR_GRP_OFS: cur = {25'h0, s.a_group};
         qsc_pkg::ATTR_VAL_OFS: cur = s.a_value;
         qsc_pkg::STATUS_OFS:   cur = {26'h0, s.status[5:3], lock, s.status[1:0]};
         qsc_pkg::RATE_SEL_OFS: cur = {21'h0, s.rate_idx, 4'h0, s.rate_cnt};
         qsc_pkg::RATE_PAIR_OFS:
            if ({1'b0, s.rate_idx} < s.rate_cnt)
               cur = s.pairs[s.rate_idx];
            else if (({1'b0, s.rate_idx} == s.rate_cnt) & s.var_rate)
               cur = qsc_pkg::VAR_PAIR;
            else
               cur = 32'h00000000;
         qsc_pkg::FREQ_OFS:     cur = s.active.freq;
         qsc_pkg::POWER_OFS:    cur = {8'h00, s.active.mute_group, s.active.mute, s.active.power};
         qsc_pkg::MODE_OFS:
            cur = {s.active.ilv_i, s.active.ilv_j, 8'h00, s.active.annex, s.active.modulation};
         qsc_pkg::RATE_OFS:     cur = {s.active.rate_m, s.active.rate_n};
         default:               cur = 32'h00000000;
      endcase
   end

   assign wd = (cur & ~mask) | (avs_writedata_i & mask);

   // Requested pair must be one of the advertised ones, or with variable rate set any pair whose low half is nonzero
   always_comb
   begin
      rate_ok = s.var_rate & (wd[15:0] != 16'h0000);
      for (int i = 0; i < qsc_pkg::RATE_PAIRS; i++)
         if ((4'(i) < s.rate_cnt) & (s.pairs[i] == wd))
            rate_ok = 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb
   begin
      next_s           = s;
      next_s.ack       = req & ~s.ack;
      next_s.disc      = 1'b0;
      next_s.seg.valid = 1'b0;
      next_s.seg.first = 1'b0;
      next_s.seg.last  = 1'b0;
      rem_now          = s.seg_rem;
      if (avs_read_i & ~s.ack)
         next_s.rdata = cur;

      if (wr_now)
      begin
         case (avs_address_i & 8'hFC)
            qsc_pkg::CTRL_OFS:
            begin
               next_s.udp         = wd[qsc_pkg::CTRL_UDP_BIT];
               next_s.sess_stream = wd[qsc_pkg::CTRL_STREAM_BIT];
               next_s.var_rate    = wd[qsc_pkg::CTRL_VAR_BIT];
               next_s.parse_en    = wd[qsc_pkg::CTRL_EN_BIT];
               if (wd[qsc_pkg::CTRL_APPLY_BIT])
               begin
                  if ((s.rate_cnt == 4'h0) & ~wd[qsc_pkg::CTRL_VAR_BIT])
                     next_s.status[qsc_pkg::ST_REFUSED_BIT] = 1'b1;
                  else
                  begin
                     next_s.active                          = s.stage;
                     next_s.status[qsc_pkg::ST_APPLIED_BIT] = 1'b1;
                  end
               end
            end
            qsc_pkg::SESS_OFS:     next_s.sess_id = wd;
            qsc_pkg::ATTR_HDR_OFS:
            begin
               next_s.a_type = wd[15:0];
               next_s.a_len  = wd[25:16];
            end
            qsc_pkg::ATTR_GRP_OFS: next_s.a_group = wd[6:0];
            qsc_pkg::ATTR_VAL_OFS:
            begin
               next_s.a_value                          = wd;
               next_s.status[qsc_pkg::ST_ATTR_ERR_BIT] = 1'b1;
               case (s.a_type)
                  qsc_pkg::TYPE_FREQ:
                     if (s.a_len == qsc_pkg::LEN_FREQ)
                     begin
                        next_s.stage.freq = wd;
                        next_s.status[qsc_pkg::ST_ATTR_ERR_BIT] = s.status[0];
                     end
                  qsc_pkg::TYPE_POWER:
                     if (s.a_len == qsc_pkg::LEN_WORD)
                     begin
                        next_s.stage.power = wd[15:0];
                        next_s.status[qsc_pkg::ST_ATTR_ERR_BIT] = s.status[0];
                     end
                  qsc_pkg::TYPE_MOD:
                     if ((s.a_len == qsc_pkg::LEN_SHORT) & (wd[3:0] <= qsc_pkg::MOD_LAST))
                     begin
                        next_s.stage.modulation = wd[3:0];
                        next_s.status[qsc_pkg::ST_ATTR_ERR_BIT] = s.status[0];
                     end
                  qsc_pkg::TYPE_ANNEX:
                     if ((s.a_len == qsc_pkg::LEN_SHORT) & (wd[3:0] <= qsc_pkg::ANNEX_LAST))
                     begin
                        next_s.stage.annex = wd[3:0];
                        next_s.status[qsc_pkg::ST_ATTR_ERR_BIT] = s.status[0];
                     end
                  qsc_pkg::TYPE_RATE:
                     if ((s.a_len == qsc_pkg::LEN_SHORT + qsc_pkg::LEN_PAIR) & rate_ok)
                     begin
                        next_s.stage.rate_m = wd[31:16];
                        next_s.stage.rate_n = wd[15:0];
                        next_s.status[qsc_pkg::ST_ATTR_ERR_BIT] = s.status[0];
                     end
                  qsc_pkg::TYPE_ILV:
                     if (s.a_len == qsc_pkg::LEN_WORD)
                     begin
                        next_s.stage.ilv_i = wd[15:8];
                        next_s.stage.ilv_j = wd[7:0];
                        next_s.status[qsc_pkg::ST_ATTR_ERR_BIT] = s.status[0];
                     end
                  qsc_pkg::TYPE_MUTE:
                     if (s.a_len == qsc_pkg::LEN_SHORT)
                     begin
                        next_s.stage.mute       = wd[0];
                        next_s.stage.mute_group = s.a_group;
                        next_s.status[qsc_pkg::ST_ATTR_ERR_BIT] = s.status[0];
                     end
                  default: next_s.status[qsc_pkg::ST_ATTR_ERR_BIT] = 1'b1;
               endcase
               if (next_s.status[0] == s.status[0] || s.status[0])
                  next_s.stage.attr_group = s.a_group;
            end
            qsc_pkg::STATUS_OFS:   next_s.status = s.status & ~wd[5:0];
            qsc_pkg::RATE_SEL_OFS:
            begin
               next_s.rate_cnt = (wd[3:0] > 4'(qsc_pkg::RATE_PAIRS)) ?
                                 4'(qsc_pkg::RATE_PAIRS) : wd[3:0];
               next_s.rate_idx = wd[10:8];
            end
            qsc_pkg::RATE_PAIR_OFS: next_s.pairs[s.rate_idx] = wd;
            default: ;
         endcase
      end

      // Packet parser
      if (vb)
      begin
         if (in_hdr)
         begin
            if (s.st == qsc_pkg::P_IDLE)
            begin
               next_s.st         = qsc_pkg::P_HDR;
               next_s.pkt_stream = pkt_stream_i;
            end
            next_s.off = o + 16'h0001;
            if ((o == hoff) & pkt_data_i[7])
               next_s.st = qsc_pkg::P_DROP;
            if ((o == hoff + 16'h0001) & (pkt_data_i[3:0] != qsc_pkg::L2_VERSION))
               next_s.st = qsc_pkg::P_DROP;
            if ((o >= hoff + 16'h0004) & (pkt_data_i != s.sess_id[31 - 8*k -: 8]))
               next_s.st = qsc_pkg::P_DROP;
            if ((o == hoff + qsc_pkg::HDR_LAST) & (next_s.st == qsc_pkg::P_HDR))
            begin
               next_s.st  = qsc_pkg::P_SUB;
               next_s.off = 16'h0000;
            end
         end
         else
         begin
            case (s.st)
               qsc_pkg::P_SUB:
               begin
                  next_s.off = s.off + 16'h0001;
                  if (s.off == 16'h0000)
                  begin
                     if (pkt_data_i[7] | (pkt_data_i[5:4] != 2'b00))
                     begin
                        next_s.st                              = qsc_pkg::P_DROP;
                        next_s.status[qsc_pkg::ST_DISCARD_BIT] = 1'b1;
                     end
                     else if (s.pkt_stream != s.sess_stream)
                     begin
                        next_s.st                           = qsc_pkg::P_DROP;
                        next_s.disc                         = 1'b1;
                        next_s.status[qsc_pkg::ST_DISC_BIT] = 1'b1;
                     end
                  end
                  if ((s.off == 16'h0001) & s.pkt_stream)
                  begin
                     next_s.seg_cnt = pkt_data_i[6:0];
                     if ((pkt_data_i[6:0] == 7'h00) | (pkt_data_i[6:0] > 7'(qsc_pkg::MAX_SEG)))
                     begin
                        next_s.st                              = qsc_pkg::P_DROP;
                        next_s.status[qsc_pkg::ST_DISCARD_BIT] = 1'b1;
                     end
                  end
                  if (s.off == qsc_pkg::SUB_LAST)
                  begin
                     next_s.st      = s.pkt_stream ? qsc_pkg::P_TABLE : qsc_pkg::P_PAY;
                     next_s.off     = 16'h0000;
                     next_s.seg_idx = 7'h00;
                     next_s.new_seg = 1'b1;
                  end
               end
               qsc_pkg::P_TABLE:
               begin
                  next_s.off = s.off + 16'h0001;
                  if (!s.off[0])
                     next_s.lens[s.seg_idx[3:0]][13:8] = pkt_data_i[5:0];
                  else
                  begin
                     next_s.lens[s.seg_idx[3:0]][7:0] = pkt_data_i;
                     next_s.seg_idx                   = s.seg_idx + 7'h01;
                     if (s.seg_idx + 7'h01 == s.seg_cnt)
                     begin
                        next_s.st      = qsc_pkg::P_PAY;
                        next_s.seg_idx = 7'h00;
                     end
                  end
               end
               qsc_pkg::P_PAY:
               begin
                  if (s.new_seg)
                     rem_now = s.pkt_stream ? s.lens[s.seg_idx[3:0]] : qsc_pkg::MPEG_SEG_LEN;
                  if (rem_now == 14'h0000)
                  begin
                     next_s.st                              = qsc_pkg::P_DROP;
                     next_s.status[qsc_pkg::ST_DISCARD_BIT] = 1'b1;
                  end
                  else
                  begin
                     next_s.seg.valid = 1'b1;
                     next_s.seg.data  = pkt_data_i;
                     next_s.seg.first = s.new_seg;
                     next_s.seg.last  = (rem_now == 14'h0001);
                     next_s.seg_rem   = rem_now - 14'h0001;
                     next_s.new_seg   = (rem_now == 14'h0001);
                     if (rem_now == 14'h0001)
                     begin
                        next_s.seg_idx = s.seg_idx + 7'h01;
                        if (s.pkt_stream & (s.seg_idx + 7'h01 == s.seg_cnt))
                           next_s.st = qsc_pkg::P_DROP;
                     end
                  end
               end
               default: ;
            endcase
         end
         if (pkt_eop_i)
            next_s.st = qsc_pkg::P_IDLE;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_q)
   begin
      if (!rst_q)
         s <= '0;
      else
         s <= next_s;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rst_q);

   sequence attr_write(logic [15:0] t, logic [9:0] l);
      wr_now & ((avs_address_i & 8'hFC) == qsc_pkg::ATTR_VAL_OFS) & (s.a_type == t) &
      (s.a_len == l);
   endsequence

   one_wait_a: assert property (req & ~s.ack |=> ~avs_waitrequest_o)
      else $error("bus answer not after one wait state");
   freq_decode_a: assert property (attr_write(qsc_pkg::TYPE_FREQ, qsc_pkg::LEN_FREQ)
      |=> s.stage.freq == $past(wd)) else $error("frequency not decoded");
   power_decode_a: assert property (attr_write(qsc_pkg::TYPE_POWER, qsc_pkg::LEN_WORD)
      |=> s.stage.power == $past(wd[15:0])) else $error("power not decoded");
   mod_reserved_a: assert property (attr_write(qsc_pkg::TYPE_MOD, qsc_pkg::LEN_SHORT)
      ##0 (wd[3:0] > 4'h1) |=> $stable(s.stage.modulation) & s.status[0])
      else $error("reserved modulation accepted");
   annex_reserved_a: assert property (attr_write(qsc_pkg::TYPE_ANNEX, qsc_pkg::LEN_SHORT)
      ##0 (wd[3:0] > 4'h2) |=> $stable(s.stage.annex) & s.status[0])
      else $error("reserved annex accepted");
   lock_flag_a: assert property (s.var_rate |-> ~avs_readdata_o[2]
      or ~($past(avs_read_i) & ($past(avs_address_i) == qsc_pkg::STATUS_OFS)))
      else $error("lock flag set with variable rate");
   refuse_setup_a: assert property (wr_now & ((avs_address_i & 8'hFC) == qsc_pkg::CTRL_OFS)
      & wd[3] & ~wd[2] & (s.rate_cnt == 4'h0) |=> s.status[1] & $stable(s.active))
      else $error("setup not refused");
   apply_only_a: assert property (~(wr_now & ((avs_address_i & 8'hFC) == qsc_pkg::CTRL_OFS))
      |=> $stable(s.active)) else $error("settings applied without confirm");
   disc_pulse_a: assert property (disconnect_o |-> ##1 ~disconnect_o ##0 s.status[4])
      else $error("disconnect not a single pulse");
   seg_mpeg_a: assert property (seg_o.valid & seg_o.first & ~s.pkt_stream
      |-> s.seg_rem == qsc_pkg::MPEG_SEG_LEN - 14'h0001) else $error("segment not 188 bytes");

endmodule

// File: testbench/qsc_core_tx.sv
`timescale 1ns/100ps
module qsc_core_tx
(
   input  wire logic       clk_i,
   output logic            valid_o,
   output logic [7:0]      data_o,
   output logic            sop_o,
   output logic            eop_o
);
   initial
   begin
      valid_o = 0;
      data_o = 8'hA5;
      sop_o = 0;
      eop_o = 0;
   end

   // No UDP header, no cookie
   task automatic send(input logic [31:0] sid, input int n, input logic [7:0] sub0);
      logic [7:0] b [$];
      b = '{8'h00, 8'h03, 8'h00, 8'h00};
      for (int i = 3; i >= 0; i--)
         b.push_back(sid[8*i+:8]);
      b.push_back(sub0);
      repeat (3) b.push_back(8'h00);
      for (int i = 0; i < n; i++)
         b.push_back(i[7:0] ^ sid[7:0]);
      foreach (b[i])
      begin
         @(posedge clk_i);
         valid_o <= 1;
         data_o <= b[i];
         sop_o <= (i == 0);
         eop_o <= (i == b.size() - 1);
      end
      @(posedge clk_i);
      valid_o <= 0;
      data_o <= ~data_o;
      sop_o <= 0;
      eop_o <= 0;
   endtask
endmodule

// File: testbench/qsc_top_tb.sv
`timescale 1ns/100ps
module qsc_top_tb;
   logic              clk, rstn, rd, wr, strm, vld, sop, eop, rdy, wreq, disc;
   logic [7:0]        addr, data, fd;
   logic [31:0]       wd, q, rdata, sid, v;
   qsc_pkg::qsc_seg_s seg;
   qsc_pkg::qsc_phy_s phy;
   int                errors, checks_done, seed, nseg, nf, nl, nd;

   qsc_top dut_u (.ref_clk_i(clk), .rstn_i(rstn), .avs_address_i(addr), .avs_read_i(rd),
      .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hF), .avs_readdata_o(rdata),
      .avs_waitrequest_o(wreq), .pkt_valid_i(vld), .pkt_data_i(data), .pkt_sop_i(sop),
      .pkt_eop_i(eop), .pkt_stream_i(strm), .pkt_ready_o(rdy), .seg_o(seg),
      .disconnect_o(disc), .phy_o(phy));
   qsc_core_tx tx_u (.clk_i(clk), .valid_o(vld), .data_o(data), .sop_o(sop), .eop_o(eop));

   initial
   begin
      clk = 0;
      forever #2.5 clk = ~clk;
   end

   always @(posedge clk)
   begin
      nseg += (seg.valid === 1'b1);
      nf += (seg.valid === 1'b1 && seg.first === 1'b1);
      nl += (seg.valid === 1'b1 && seg.last === 1'b1);
      nd += (disc === 1'b1);
      if (seg.valid === 1'b1 && seg.first === 1'b1)
         fd = seg.data;
   end

   // Reserved codes lie above the last defined one
   function automatic logic bad_code(input int c, input logic [3:0] last);
      return c > last;
   endfunction

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // Avalon master: hold request until waitrequest low at a rising edge
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      addr <= a;
      wr <= w;
      rd <= !w;
      wd <= d;
      do @(posedge clk); while (wreq !== 1'b0 && ++n < 50);
      if (n >= 50)
      begin
         errors++;
         results();
      end
      else
      begin
         q = rdata;
         rd <= 0;
         wr <= 0;
      end
   endtask

   task automatic attr(input logic [15:0] t, input logic [9:0] l, input logic [31:0] d, input e);
      bus(1, qsc_pkg::ATTR_HDR_OFS, {6'h00, l, t});
      bus(1, qsc_pkg::ATTR_VAL_OFS, d);
      bus(0, qsc_pkg::STATUS_OFS, 0);
      chk("attr_err", q[0], e);
      bus(1, qsc_pkg::STATUS_OFS, 32'h3F);
   endtask

   task automatic pkt(input s, input logic [31:0] id, input int n, input logic [7:0] sb,
                      input int es, input int ed);
      @(posedge clk);
      strm <= s;
      @(negedge clk);
      {nseg, nf, nl, nd} = 0;
      fd = 8'h00;
      tx_u.send(id, n, sb);
      repeat (3) @(posedge clk);
      chk("segs", nseg, es);
      chk("first_last", {nf[15:0], nl[15:0]}, es ? 32'h10001 : 0);
      chk("disc", nd, ed);
      if (es)
         chk("first_data", fd, id[7:0]);
      $display("packet test done");
   endtask

   initial
   begin
      {rstn, rd, wr, strm, addr, wd} = 0;
      seed = 55769;
      repeat (100000) @(posedge clk);
      errors++;
      results();
   end

   initial
   begin
      #0;
      repeat (5) @(posedge clk);
      chk("ready_rst", rdy, 0);
      rstn <= 1;
      repeat (4) @(posedge clk);
      chk("ready", rdy, 1);
      sid = $random(seed);
      bus(1, qsc_pkg::SESS_OFS, sid);
      bus(1, qsc_pkg::CTRL_OFS, 32'h18);
      bus(0, qsc_pkg::STATUS_OFS, 0);
      chk("refused", q[3:1], 3'b001);
      v = $random(seed);
      bus(1, qsc_pkg::RATE_SEL_OFS, 32'h1);
      bus(1, qsc_pkg::RATE_PAIR_OFS, v);
      bus(0, qsc_pkg::RATE_PAIR_OFS, 0);
      chk("pair", q, v);
      bus(0, qsc_pkg::STATUS_OFS, 0);
      chk("lock", q[2], 1);
      attr(qsc_pkg::TYPE_RATE, qsc_pkg::LEN_SHORT + qsc_pkg::LEN_PAIR, v, 0);
      attr(qsc_pkg::TYPE_RATE, qsc_pkg::LEN_SHORT + qsc_pkg::LEN_PAIR, v ^ 32'h1, 1);
      attr(qsc_pkg::TYPE_FREQ, qsc_pkg::LEN_FREQ, v, 0);
      attr(qsc_pkg::TYPE_POWER, qsc_pkg::LEN_WORD, v, 0);
      attr(qsc_pkg::TYPE_POWER, qsc_pkg::LEN_SHORT, 0, 1);
      for (int c = 0; c < 16; c++)
      begin
         attr(qsc_pkg::TYPE_MOD, qsc_pkg::LEN_SHORT, c, bad_code(c, qsc_pkg::MOD_LAST));
         attr(qsc_pkg::TYPE_ANNEX, qsc_pkg::LEN_SHORT, c, bad_code(c, qsc_pkg::ANNEX_LAST));
      end
      attr(qsc_pkg::TYPE_ILV, qsc_pkg::LEN_WORD, v, 0);
      bus(1, qsc_pkg::ATTR_GRP_OFS, 32'h5A);
      attr(qsc_pkg::TYPE_MUTE, qsc_pkg::LEN_SHORT, 32'hFF, 0);
      chk("staged", phy.freq, 0);
      bus(1, qsc_pkg::CTRL_OFS, 32'h1C);
      @(negedge clk);
      chk("freq", phy.freq, v);
      chk("rate", {phy.rate_m, phy.rate_n}, v);
      chk("group", {phy.mute_group, phy.attr_group}, {7'h5A, 7'h5A});
      chk("power", phy.power, v[15:0]);
      chk("mode", {phy.modulation, phy.annex}, 8'h12);
      chk("ilv", {phy.ilv_i, phy.ilv_j}, v[15:0]);
      chk("mute", phy.mute, 1);
      bus(1, qsc_pkg::RATE_SEL_OFS, 32'h101);
      bus(0, qsc_pkg::RATE_PAIR_OFS, 0);
      chk("var_pair", q, qsc_pkg::VAR_PAIR);
      bus(0, qsc_pkg::STATUS_OFS, 0);
      chk("lock_applied", q[3:2], 2'b10);
      bus(0, 8'hF0, 0);
      chk("unmapped", q, 0);
      $display("register test done");
      bus(1, qsc_pkg::CTRL_OFS, 32'h14);
      pkt(0, sid, 188, 8'h00, 188, 0);
      pkt(0, sid ^ 32'h1, 20, 8'h00, 0, 0);
      pkt(1, sid, 20, 8'h00, 0, 1);
      pkt(0, sid, 20, 8'h80, 0, 0);
      bus(0, qsc_pkg::STATUS_OFS, 0);
      chk("flags", q[5:4], 2'b11);
      results();
   end
endmodule
